//--- logic/rx_desc_pkg.sv
`default_nettype none
package rx_desc_pkg;
  // ********************************************************************
  // Receive queue geometry and descriptor layout.
  // ********************************************************************
  localparam int QUEUE_BYTES = 4096;
  localparam int RAM_AW = 11;
  localparam int RAM_DW = 16;
  localparam logic [10:0] DESC_STAT_OFS = 11'h000;
  localparam logic [10:0] DESC_CNT_OFS = 11'h002;
  localparam logic [10:0] DESC_DATA_OFS = 11'h004;
  localparam logic [10:0] STAT_WORD = DESC_STAT_OFS >> 1;
  localparam logic [10:0] CNT_WORD = DESC_CNT_OFS >> 1;
  localparam logic [10:0] DATA_WORD = DESC_DATA_OFS >> 1;
  localparam logic [11:0] MAX_DATA_BYTES = 12'h077C;
  localparam logic [11:0] RAW_LIMIT = MAX_DATA_BYTES + 12'h0004;
  localparam logic [11:0] CRC_BYTES = 12'h0004;
  localparam logic [15:0] MAX_LEN_FIELD = 16'h05DC;
  localparam logic [11:0] OVERSIZE_LEN = 12'h05EE;
  localparam logic [11:0] DA_BYTES = 12'h0006;
  localparam logic [11:0] TYPE_HI_IDX = 12'h000C;
  localparam logic [11:0] TYPE_LO_IDX = 12'h000D;
  localparam logic [7:0] BCAST_BYTE = 8'hFF;

  // ********************************************************************
  // Status word and byte-count word fields.
  // ********************************************************************
  localparam int ST_VALID_BIT = 15;
  localparam int ST_PORT_LSB = 8;
  localparam int ST_BCAST_BIT = 7;
  localparam int ST_MCAST_BIT = 6;
  localparam int ST_UCAST_BIT = 5;
  localparam int ST_ETYPE_BIT = 3;
  localparam int ST_OVERSIZE_BIT = 2;
  localparam int ST_SHORT_BIT = 1;
  localparam int ST_CRC_BIT = 0;
  localparam int CNT_MSB = 10;
  localparam logic [1:0] PORT_ONE = 2'h1;
  localparam logic [1:0] PORT_TWO = 2'h2;

  // ********************************************************************
  // Register map, byte addresses, and control fields.
  // ********************************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_COUNT = 5'h08;
  localparam logic [4:0] REG_DATA = 5'h0C;
  localparam logic [4:0] REG_RELEASE = 5'h10;
  localparam logic [4:0] REG_INFO = 5'h14;
  localparam int CTRL_PASS_BAD_BIT = 0;
  localparam int CTRL_STRIP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {
    W_RECV = 2'b00,
    W_DROP = 2'b01,
    W_CNT = 2'b10,
    W_STAT = 2'b11
  } wr_state_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_MEM = 2'b01,
    B_ACK = 2'b10
  } bus_state_t;
endpackage
`default_nettype wire

//--- logic/rx_frame_ram.sv
`timescale 1ns/10ps
`default_nettype none
module rx_frame_ram #(
  parameter int AW = 11,
  parameter int DW = 16
) (
  // Clock and enable.
  input wire logic i_clk,
  input wire logic i_ce,
  // Write port.
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Read port.
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port; contents are not reset, pointers decide what is valid.
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read, data valid one cycle after the strobe.
  always_ff @(posedge i_clk) begin
    if (i_ce && i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

//--- logic/rx_queue_frame_descriptor.sv
// Summary of operation
// - Frame stored as status word, count word, then data from offset four.
// - Count word holds number of frame bytes stored in the data area.
// - Data area of one frame holds at most 1916 bytes.
// - Trailing checksum stored only when checksum stripping is off.
// - Status register mirrors the frame at the queue head once its descriptor is loaded.
// - Valid bit 15 set only for a complete frame with valid fields.
// - Valid bit reads clear with no frame or while one is arriving.
// - Bits 9-8 give ingress port, 01 port one, 10 port two only.
// - Bit 7 set for broadcast destination address.
// - Bit 6 set for multicast destination, broadcast included.
// - Bit 5 set for unicast destination address.
// - Bit 3 set when length/type exceeds 1500, clear otherwise.
// - Host ignores bit 3 whenever the short frame flag is set.
// - Bit 2 set when frame is longer than 1518 bytes.
// - Oversize frames kept only when pass-bad is enabled.
// - Oversize flag is informational; kept frames are never truncated.
// - Bit 1 set for frames cut short by collision or early end.
// - Short frames kept only when pass-bad is enabled.
// - Bit 0 set on checksum mismatch of the frame.
// - Checksum error frames kept only when pass-bad is enabled.
// - Count in bits 10-0, bits 15-11 reserved.
// - Four kilobytes of queue memory hold frames back to back.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rx_queue_frame_descriptor
  import rx_desc_pkg::*;
(
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Receive byte stream from the switch and MAC.
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic [1:0] i_rx_port,
  input wire logic i_rx_short,
  input wire logic i_rx_crc_err,
  // Avalon-MM slave.
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Queue head status.
  output logic o_rx_frame_pending
);
  // ********************************************************************
  // Declarations.
  // ********************************************************************
  wr_state_t wst_ff;
  bus_state_t bst_ff;
  logic [11:0] idx_ff, raw_len, nxt_stored;
  logic [7:0] lo_ff, thi_ff, dropped_ff;
  logic bcast_ff, mcast_ff, etype_ff, loaded_ff, wait_ff;
  logic [RAM_AW-1:0] wbase_ff, wptr_ff, frames_ff, rd_base_ff, rd_ptr_ff;
  logic [15:0] st_word_ff, head_st_ff, head_cnt_ff;
  logic [10:0] stored_ff;
  logic [1:0] ld_step_ff, ctrl_ff;
  logic [31:0] readdata_ff, reg_rdata;
  logic nxt_bcast, nxt_mcast, nxt_etype, port_ok, oversize, bad, keep, room_ok;
  logic [15:0] nxt_status, mem_wdata, mem_rdata;
  logic mem_we, mem_re, ld_re, bus_data_re, bus_release, commit;
  logic [RAM_AW-1:0] mem_waddr, mem_raddr;

  // ********************************************************************
  // Per-byte classification of the arriving frame.
  // ********************************************************************
  // Address flags come from the first destination byte onward.
  always_comb begin
    nxt_bcast = bcast_ff;
    nxt_mcast = mcast_ff;
    nxt_etype = etype_ff;
    if (idx_ff == 12'h000) begin
      nxt_mcast = i_rx_data[0];
      nxt_bcast = (i_rx_data == BCAST_BYTE);
    end else if (idx_ff < DA_BYTES) begin
      nxt_bcast = bcast_ff & (i_rx_data == BCAST_BYTE);
    end
    if (idx_ff == TYPE_LO_IDX) begin
      nxt_etype = ({thi_ff, i_rx_data} > MAX_LEN_FIELD);
    end
  end

  // ********************************************************************
  // End-of-frame decisions, valid in the cycle of the last byte.
  // ********************************************************************
  assign raw_len = idx_ff + 12'h001;
  // With stripping on, the four checksum bytes stay out of the count.
  assign nxt_stored = !ctrl_ff[CTRL_STRIP_BIT] ? raw_len :
                      (raw_len > CRC_BYTES) ? (raw_len - CRC_BYTES) : 12'h000;
  assign port_ok = (i_rx_port == PORT_ONE) || (i_rx_port == PORT_TWO);
  assign oversize = (raw_len > OVERSIZE_LEN);
  assign bad = oversize | i_rx_short | i_rx_crc_err;
  // Bad frames are dropped unless pass-bad is set
  assign keep = port_ok && (nxt_stored <= MAX_DATA_BYTES) &&
                (ctrl_ff[CTRL_PASS_BAD_BIT] || !bad);
  // Stop before overwriting the head frame or passing the data limit.
  assign room_ok = (wptr_ff != rd_base_ff) && (idx_ff < RAW_LIMIT);

  // Status word; valid is set here but written last.
  always_comb begin
    nxt_status = 16'h0000;
    nxt_status[ST_VALID_BIT] = 1'b1;
    nxt_status[ST_PORT_LSB+1:ST_PORT_LSB] = i_rx_port;
    nxt_status[ST_BCAST_BIT] = nxt_bcast;
    nxt_status[ST_MCAST_BIT] = nxt_mcast;
    nxt_status[ST_UCAST_BIT] = !nxt_mcast;
    // Undefined for short frames, the host must not rely on it.
    nxt_status[ST_ETYPE_BIT] = nxt_etype;
    nxt_status[ST_OVERSIZE_BIT] = oversize;
    nxt_status[ST_SHORT_BIT] = i_rx_short;
    nxt_status[ST_CRC_BIT] = i_rx_crc_err;
  end

  // ********************************************************************
  // Memory write port: packed data words, then count, then status.
  // ********************************************************************
  // First byte sits in the low half of each word.
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = wptr_ff;
    mem_wdata = idx_ff[0] ? {i_rx_data, lo_ff} : {8'h00, i_rx_data};
    case (wst_ff)
      W_RECV: mem_we = i_rx_valid && room_ok && (idx_ff[0] || i_rx_last);
      W_CNT: begin
        mem_we = 1'b1;
        mem_waddr = wbase_ff + CNT_WORD;
        mem_wdata = {5'h00, stored_ff};
      end
      W_STAT: begin
        mem_we = 1'b1;
        mem_waddr = wbase_ff + STAT_WORD;
        mem_wdata = st_word_ff;
      end
      default: mem_we = 1'b0;
    endcase
  end

  // ********************************************************************
  // Frame writer.
  // ********************************************************************
  // Bytes arriving during the two descriptor cycles are not accepted.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wst_ff <= W_RECV;
      idx_ff <= 12'h000;
      lo_ff <= 8'h00;
      bcast_ff <= 1'b0;
      mcast_ff <= 1'b0;
      thi_ff <= 8'h00;
      etype_ff <= 1'b0;
      wbase_ff <= 11'h000;
      wptr_ff <= DATA_WORD;
      st_word_ff <= 16'h0000;
      stored_ff <= 11'h000;
      dropped_ff <= 8'h00;
    end else if (i_ce) begin
      case (wst_ff)
        W_RECV: begin
          if (i_rx_valid) begin
            idx_ff <= idx_ff + 12'h001;
            lo_ff <= i_rx_data;
            bcast_ff <= nxt_bcast;
            mcast_ff <= nxt_mcast;
            etype_ff <= nxt_etype;
            if (idx_ff == TYPE_HI_IDX) begin
              thi_ff <= i_rx_data;
            end
            if (mem_we) begin
              wptr_ff <= wptr_ff + 11'h001;
            end
            if (!room_ok || (i_rx_last && !keep)) begin
              dropped_ff <= dropped_ff + 8'h01;
            end
            if (!room_ok && !i_rx_last) begin
              wst_ff <= W_DROP;
            end else if (i_rx_last) begin
              idx_ff <= 12'h000;
              etype_ff <= 1'b0;
              if (room_ok && keep) begin
                st_word_ff <= nxt_status;
                stored_ff <= nxt_stored[10:0];
                wst_ff <= W_CNT;
              end else begin
                wptr_ff <= wbase_ff + DATA_WORD;
              end
            end
          end
        end
        W_DROP: begin
          if (i_rx_valid && i_rx_last) begin
            idx_ff <= 12'h000;
            etype_ff <= 1'b0;
            wptr_ff <= wbase_ff + DATA_WORD;
            wst_ff <= W_RECV;
          end
        end
        W_CNT: wst_ff <= W_STAT;
        W_STAT: begin
          // Next frame starts right after this one.
          wbase_ff <= wbase_ff + DATA_WORD + 11'((12'(stored_ff) + 12'h001) >> 1);
          wptr_ff <= wbase_ff + DATA_WORD + DATA_WORD +
                     11'((12'(stored_ff) + 12'h001) >> 1);
          wst_ff <= W_RECV;
        end
        default: wst_ff <= W_RECV;
      endcase
    end
  end

  // ********************************************************************
  // Count of committed frames in the queue.
  // ********************************************************************
  assign commit = (wst_ff == W_STAT);

  // Commit and release in one cycle cancel out.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      frames_ff <= 11'h000;
    end else if (i_ce) begin
      if (commit && !bus_release) begin
        frames_ff <= frames_ff + 11'h001;
      end else if (!commit && bus_release) begin
        frames_ff <= frames_ff - 11'h001;
      end
    end
  end

  // ********************************************************************
  // Head loader and read pointer.
  // ********************************************************************
  assign ld_re = !loaded_ff && ((ld_step_ff == 2'h0 && frames_ff != 11'h000) ||
                                ld_step_ff == 2'h1);
  assign mem_re = ld_re | bus_data_re;
  assign mem_raddr = loaded_ff ? rd_ptr_ff :
                     (ld_step_ff == 2'h0) ? rd_base_ff + STAT_WORD : rd_base_ff + CNT_WORD;

  // Head words are fetched only for committed frames.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_base_ff <= 11'h000;
      rd_ptr_ff <= 11'h000;
      loaded_ff <= 1'b0;
      ld_step_ff <= 2'h0;
      head_st_ff <= 16'h0000;
      head_cnt_ff <= 16'h0000;
    end else if (i_ce) begin
      if (loaded_ff) begin
        if (bus_data_re) begin
          rd_ptr_ff <= rd_ptr_ff + 11'h001;
        end
        if (bus_release) begin
          rd_base_ff <= rd_base_ff + DATA_WORD +
                        11'((12'(head_cnt_ff[CNT_MSB:0]) + 12'h001) >> 1);
          loaded_ff <= 1'b0;
        end
      end else begin
        case (ld_step_ff)
          2'h0: if (frames_ff != 11'h000) ld_step_ff <= 2'h1;
          2'h1: begin
            head_st_ff <= mem_rdata;
            ld_step_ff <= 2'h2;
          end
          2'h2: begin
            head_cnt_ff <= mem_rdata;
            rd_ptr_ff <= rd_base_ff + DATA_WORD;
            loaded_ff <= 1'b1;
            ld_step_ff <= 2'h0;
          end
          default: ld_step_ff <= 2'h0;
        endcase
      end
    end
  end

  assign o_rx_frame_pending = loaded_ff;

  // ********************************************************************
  // Avalon-MM register slave.
  // ********************************************************************
  assign bus_data_re = (bst_ff == B_IDLE) && i_avs_read && (i_avs_address == REG_DATA) &&
                       loaded_ff;
  assign bus_release = (bst_ff == B_IDLE) && i_avs_write &&
                       (i_avs_address == REG_RELEASE) && loaded_ff;

  // Status reads zero until a whole frame heads the queue.
  always_comb begin
    reg_rdata = 32'h0000_0000;
    case (i_avs_address)
      REG_CTRL: reg_rdata = {30'h0000_0000, ctrl_ff};
      REG_STATUS: reg_rdata = loaded_ff ? {16'h0000, head_st_ff} : 32'h0000_0000;
      REG_COUNT: reg_rdata = loaded_ff ? {16'h0000, head_cnt_ff} : 32'h0000_0000;
      REG_INFO: reg_rdata = {13'h0000, dropped_ff, frames_ff};
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  // Waitrequest drops for exactly one cycle per request.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bst_ff <= B_IDLE;
      wait_ff <= 1'b1;
      readdata_ff <= 32'h0000_0000;
      ctrl_ff <= CTRL_RESET;
    end else if (i_ce) begin
      case (bst_ff)
        B_IDLE: begin
          if (bus_data_re) begin
            bst_ff <= B_MEM;
          end else if (i_avs_read || i_avs_write) begin
            readdata_ff <= i_avs_read ? reg_rdata : 32'h0000_0000;
            if (i_avs_write && i_avs_address == REG_CTRL) begin
              ctrl_ff <= i_avs_writedata[1:0];
            end
            wait_ff <= 1'b0;
            bst_ff <= B_ACK;
          end
        end
        B_MEM: begin
          readdata_ff <= {16'h0000, mem_rdata};
          wait_ff <= 1'b0;
          bst_ff <= B_ACK;
        end
        B_ACK: begin
          wait_ff <= 1'b1;
          bst_ff <= B_IDLE;
        end
        default: begin
          wait_ff <= 1'b1;
          bst_ff <= B_IDLE;
        end
      endcase
    end
  end

  assign o_avs_readdata = readdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // ********************************************************************
  // Queue memory, 4 KB as 16-bit words.
  // ********************************************************************
  rx_frame_ram #(
    .AW(RAM_AW),
    .DW(RAM_DW)
  ) rx_frame_ram_i (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_re(mem_re),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );
endmodule
`default_nettype wire

//--- dv/rx_queue_frame_descriptor_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rx_queue_frame_descriptor_checker
  import rx_desc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // Watched bus and status ports.
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_rx_frame_pending
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ******
  // Handshake steps.
  // ******
  sequence req_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence ack_s;
    !o_avs_waitrequest;
  endsequence

  // Read answers from the two descriptor registers.
  wire logic rd_ack = i_avs_read && !o_avs_waitrequest;
  wire logic stat_ack = rd_ack && (i_avs_address == REG_STATUS);
  wire logic cnt_ack = rd_ack && (i_avs_address == REG_COUNT);

  // A taken request must be answered, so a slow slave never hangs the host.
  ack_bound_a: assert property (req_s |-> ##[1:2] ack_s)
    else $error("request not answered in two cycles");
  ack_pulse_a: assert property (ack_s |=> !ack_s)
    else $error("waitrequest low for more than one cycle");
  ack_cause_a: assert property (ack_s |-> (i_avs_read || i_avs_write))
    else $error("answer without a request");
  reset_state_a: assert property ($fell(i_srst) |->
    o_avs_waitrequest && !o_rx_frame_pending && (o_avs_readdata == 32'h0000_0000))
    else $error("outputs not at rest after reset");
  stat_resv_a: assert property (stat_ack |->
    (o_avs_readdata[31:16] == 16'h0000) && (o_avs_readdata[14:10] == 5'h00)
    && !o_avs_readdata[4])
    else $error("reserved status bits set");
  stat_port_a: assert property (stat_ack && o_avs_readdata[15] |->
    (o_avs_readdata[9:8] == PORT_ONE) || (o_avs_readdata[9:8] == PORT_TWO))
    else $error("valid status with bad port code");
  addr_class_a: assert property (stat_ack && o_avs_readdata[15] |->
    (o_avs_readdata[5] != o_avs_readdata[6]) && (!o_avs_readdata[7] || o_avs_readdata[6]))
    else $error("address class bits inconsistent");
  cnt_field_a: assert property (cnt_ack |->
    (o_avs_readdata[31:11] == 21'h00_0000) && (o_avs_readdata[10:0] <= 11'h77C))
    else $error("byte count word out of range");
endmodule
bind rx_queue_frame_descriptor rx_queue_frame_descriptor_checker
  rx_queue_frame_descriptor_checker_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_rx_frame_pending(o_rx_frame_pending)
);
`default_nettype wire

//--- dv/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  // Clock.
  input wire logic i_clk,
  // Requests towards the queue.
  output logic [4:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  // Answers from the queue.
  input wire logic [31:0] i_readdata,
  input wire logic i_waitrequest
);
  // Bus idle from time zero.
  initial begin
    o_address = 5'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0000_0000;
  end

  // One transfer; a slave that never answers is caught by the bench watchdog.
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge i_clk);
    o_address <= a;
    o_writedata <= wd;
    o_read <= !wr;
    o_write <= wr;
    do begin
      @(posedge i_clk);
    end while (i_waitrequest);
    rd = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    o_writedata <= ~wd;
  endtask
endmodule
`default_nettype wire

//--- dv/rx_queue_frame_descriptor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rx_queue_frame_descriptor_tb
  import rx_desc_pkg::*;
;
  // Frame case: flags are short, checksum error, pass-bad, strip.
  typedef struct packed {
    logic [11:0] n;
    logic [7:0] da;
    logic [15:0] ty;
    logic [1:0] pt;
    logic [3:0] fl;
  } frame_case_t;
  logic clk, srst = 1'b1, rx_valid = 1'b0, rx_last = 1'b0;
  logic rx_short = 1'b0, rx_crc_err = 1'b0, avs_read, avs_write, avs_wait, pending;
  logic [7:0] rx_data = 8'h00;
  logic [1:0] rx_port = 2'h0;
  logic [4:0] avs_address;
  logic [31:0] avs_wdata, avs_rdata, d;
  int errors = 0, num_checks = 0;
  frame_case_t cs [13] = '{
    '{12'h040, 8'h02, 16'h0800, 2'h1, 4'h0}, '{12'h041, 8'hFF, 16'h0040, 2'h2, 4'h1},
    '{12'h03C, 8'h01, 16'h05DC, 2'h1, 4'h4}, '{12'h03C, 8'h01, 16'h05DD, 2'h1, 4'h6},
    '{12'h014, 8'h02, 16'h0800, 2'h2, 4'h8}, '{12'h014, 8'h02, 16'h0800, 2'h2, 4'hA},
    '{12'h5EF, 8'h02, 16'h0800, 2'h1, 4'h0}, '{12'h5EF, 8'h01, 16'h0800, 2'h1, 4'h2},
    '{12'h5EE, 8'h02, 16'h0800, 2'h2, 4'h0}, '{12'h040, 8'h02, 16'h0800, 2'h3, 4'h2},
    '{12'h781, 8'h02, 16'h0800, 2'h1, 4'h2}, '{12'h780, 8'h02, 16'h0800, 2'h1, 4'h3},
    '{12'h780, 8'h02, 16'h0800, 2'h1, 4'h2}};

  // Design under test; the clock enable stays on.
  rx_queue_frame_descriptor rx_queue_frame_descriptor_i (
    .i_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_last(rx_last), .i_rx_port(rx_port), .i_rx_short(rx_short),
    .i_rx_crc_err(rx_crc_err), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_wdata), .o_avs_readdata(avs_rdata),
    .o_avs_waitrequest(avs_wait), .o_rx_frame_pending(pending));
  // Host on the far side of the queue.
  host_bus_model host_bus_model_i (
    .i_clk(clk), .o_address(avs_address), .o_read(avs_read), .o_write(avs_write),
    .o_writedata(avs_wdata), .i_readdata(avs_rdata), .i_waitrequest(avs_wait));

  // ******
  // Helpers.
  // ******
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] wd);
    host_bus_model_i.bus_xfer(w, a, wd, d);
  endtask
  // Masked case compare; an unknown in a kept bit never matches.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    num_checks++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] fbyte(input frame_case_t c, input int i);
    if (i < 6) return c.da;
    if (i == 12) return c.ty[15:8];
    if (i == 13) return c.ty[7:0];
    return i[7:0];
  endfunction
  function automatic logic [15:0] exp_stat(input frame_case_t c);
    logic [15:0] s;
    s = {1'b1, 5'h00, c.pt, 8'h00};
    s[7] = (c.da == 8'hFF);
    s[6] = c.da[0];
    s[5] = !c.da[0];
    s[3] = (c.n >= 12'h00E) && (c.ty > 16'h05DC);
    s[2] = (c.n > 12'h5EE);
    s[1] = c.fl[3];
    s[0] = c.fl[2];
    return s;
  endfunction
  // Byte stream from the MAC; data is inverted when idle so stale bytes never look valid.
  task automatic send(input frame_case_t c);
    rx_port <= c.pt;
    rx_short <= c.fl[3];
    rx_crc_err <= c.fl[2];
    for (int i = 0; i < c.n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= fbyte(c, i);
      rx_last <= (i == c.n - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  // Head frame check, full readback, then release.
  task automatic check_head(input frame_case_t c, input logic [11:0] cnt);
    xfer(1'b0, REG_STATUS, 32'h0);
    cmp(d, {16'h0, exp_stat(c)}, {28'hFFF_FFFF, !c.fl[3], 3'h7});
    cmp({31'h0, pending}, 32'h1, 32'h1);
    xfer(1'b0, REG_COUNT, 32'h0);
    cmp(d, {20'h0, cnt}, '1);
    for (int k = 0; k < (cnt + 1) / 2; k++) begin
      xfer(1'b0, REG_DATA, 32'h0);
      cmp(d, {fbyte(c, 2 * k + 1), fbyte(c, 2 * k)},
          {16'hFFFF, (2 * k + 1 < cnt) ? 8'hFF : 8'h00, 8'hFF});
    end
    xfer(1'b1, REG_RELEASE, 32'h0);
    repeat (6) @(posedge clk);
  endtask
  task automatic run_case(input frame_case_t c);
    logic [11:0] cnt;
    logic drop;
    logic [7:0] old;
    cnt = c.fl[0] ? c.n - 12'h004 : c.n;
    drop = !(c.pt == 2'h1 || c.pt == 2'h2) || cnt > 12'h77C || c.n > 12'h780
           || ((c.n > 12'h5EE || c.fl[3] || c.fl[2]) && !c.fl[1]);
    xfer(1'b1, REG_CTRL, {30'h0, c.fl[0], c.fl[1]});
    xfer(1'b0, REG_INFO, 32'h0);
    old = d[18:11];
    fork
      send(c);
      begin
        repeat (8) @(posedge clk);
        xfer(1'b0, REG_STATUS, 32'h0);
        cmp(d, 32'h0, '1);
      end
    join
    repeat (8) @(posedge clk);
    xfer(1'b0, REG_INFO, 32'h0);
    cmp({24'h0, d[18:11]}, {24'h0, old + {7'h00, drop}}, '1);
    if (!drop) check_head(c, cnt);
    xfer(1'b0, REG_STATUS, 32'h0);
    cmp(d, 32'h0, '1);
  endtask

  // Verdict in one place.
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog, well past the expected run length.
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    report_and_stop;
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    xfer(1'b0, REG_CTRL, 32'h0);
    cmp(d, {30'h0, CTRL_RESET}, '1);
    xfer(1'b1, 5'h18, 32'hFFFF_FFFF);
    xfer(1'b0, 5'h18, 32'h0);
    cmp(d, 32'h0, '1);
    xfer(1'b0, REG_DATA, 32'h0);
    cmp(d, 32'h0, '1);
    foreach (cs[i]) run_case(cs[i]);
    // Two frames queued back to back, released in arrival order.
    xfer(1'b1, REG_CTRL, 32'h0);
    send(cs[0]);
    repeat (2) @(posedge clk);
    send(cs[8]);
    repeat (10) @(posedge clk);
    check_head(cs[0], 12'h040);
    check_head(cs[8], 12'h5EE);
    report_and_stop;
  end
endmodule
`default_nettype wire
